/* File: itc_top.sv */
// interval time counter with time-of-day registers and interrupt
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module itc_top
    import itc_pkg::*;
#(
    parameter int XTAL_DIV = XTAL_PER_TICK
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          xtal_pin,
    input  wire logic          power_down,
    input  wire logic [7:0]    addr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic      [DW-1:0] rdata,
    output logic               irq,
    output logic               wake,
    output logic      [7:0]    irq_vector
);
    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       prev;
        logic [7:0] div;
        logic [1:0] sel;
        logic       single;
        logic       flag;
        logic       ien;
        logic       time_clock_enable;
        logic [7:0] frac;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] icnt;
        logic [7:0] interval_match_value;
        logic [1:0] status;
        logic [1:0] mask;
        logic [7:0] rdata;
        logic       irq;
        logic       wake;
        logic [7:0] vec;
    } itc_state_t;

    localparam logic [7:0] DIV_LAST = 8'(XTAL_DIV - 1);

    itc_state_t s;
    itc_state_t n;
    logic       xedge;
    logic       tick;
    logic       fwrap;
    logic       swrap;
    logic       mwrap;
    logic       hwrap;
    logic       step;
    logic       match_evt;
    logic [7:0] cnt_inc;

    function automatic logic [7:0] itc_inc_wrap(input logic [7:0] v, input logic [7:0] max);
        itc_inc_wrap = (v >= max) ? 8'h00 : 8'(v + 8'h01);
    endfunction : itc_inc_wrap

    always_comb begin
        n         = s;
        // crystal pin synchroniser, only second stage is observed
        n.sync1   = xtal_pin;
        n.sync2   = s.sync1;
        n.prev    = s.sync2;
        xedge     = s.sync2 & ~s.prev;
        tick      = 1'b0;
        match_evt = 1'b0;
        cnt_inc   = 8'(s.icnt + 8'h01);
        n.wake    = 1'b0;
        // 1/128 s ticks derived from crystal edges
        if (s.time_clock_enable && xedge) begin
            if (s.div == DIV_LAST) begin
                n.div = 8'h00;
                tick  = 1'b1;
            end else begin
                n.div = 8'(s.div + 8'h01);
            end
        end
        fwrap = tick && (s.frac == FRAC_MAX);
        swrap = fwrap && (s.sec == SEC_MAX);
        mwrap = swrap && (s.min == MIN_MAX);
        hwrap = mwrap && (s.hour == HOUR_MAX);
        if (tick) begin
            n.frac = itc_inc_wrap(s.frac, FRAC_MAX);
        end
        if (fwrap) begin
            n.sec = itc_inc_wrap(s.sec, SEC_MAX);
        end
        if (swrap) begin
            n.min = itc_inc_wrap(s.min, MIN_MAX);
        end
        if (mwrap) begin
            n.hour = itc_inc_wrap(s.hour, HOUR_MAX);
        end
        // timebase selection, up to 256 steps of an hour
        case (s.sel)
            SEL_FRAC: step = tick;
            SEL_SEC:  step = fwrap;
            SEL_MIN:  step = swrap;
            default:  step = mwrap;
        endcase
        if (s.ien && step) begin
            if (cnt_inc == s.interval_match_value) begin
                match_evt = 1'b1;
                n.icnt    = 8'h00;
                if (s.single) begin
                    n.ien = 1'b0;
                end
            end else begin
                n.icnt = cnt_inc;
            end
        end
        // register writes
        if (wr) begin
            if (addr == ADDR_CTRL) begin
                n.sel    = wdata[CTRL_SEL_HI:CTRL_SEL_LO];
                n.single = wdata[CTRL_SINGLE];
                n.ien    = wdata[CTRL_IEN];
                n.time_clock_enable   = wdata[CTRL_TIME_CLOCK_ENABLE];
                if (!wdata[CTRL_FLAG]) begin
                    n.flag = 1'b0;
                end
            end else if (addr == ADDR_FRAC && !s.time_clock_enable) begin
                n.frac = wdata & FRAC_MAX;
            end else if (addr == ADDR_SEC && !s.time_clock_enable) begin
                n.sec = wdata;
            end else if (addr == ADDR_MIN && !s.time_clock_enable) begin
                n.min = wdata;
            end else if (addr == ADDR_HOUR && !s.time_clock_enable) begin
                n.hour = wdata;
            end else if (addr == ADDR_INTERVAL_MATCH_VALUE) begin
                n.interval_match_value = wdata;
            end else if (addr == ADDR_STATUS) begin
                n.status = s.status & ~wdata[1:0];
            end else if (addr == ADDR_MASK) begin
                n.mask = wdata[1:0];
            end
        end
        // disabling the time clock zeroes the timebase
        if (s.time_clock_enable && !n.time_clock_enable) begin
            n.div  = 8'h00;
            n.frac = 8'h00;
            n.sec  = 8'h00;
            n.min  = 8'h00;
            n.hour = 8'h00;
        end
        if (!n.ien) begin
            n.icnt = 8'h00;
        end
        // hardware sets win over software clears
        if (match_evt) begin
            n.flag             = 1'b1;
            n.status[ST_MATCH] = 1'b1;
            n.wake             = power_down && s.mask[ST_MATCH];
        end
        if (hwrap) begin
            n.status[ST_DAY] = 1'b1;
        end
        n.irq = |(n.status & n.mask);
        // read data one cycle after the strobe
        n.rdata = 8'h00;
        if (rd) begin
            if (addr == ADDR_CTRL) begin
                n.rdata = {2'b00, s.sel, s.single, s.flag, s.ien, s.time_clock_enable};
            end else if (addr == ADDR_FRAC) begin
                n.rdata = s.frac;
            end else if (addr == ADDR_SEC) begin
                n.rdata = s.sec;
            end else if (addr == ADDR_MIN) begin
                n.rdata = s.min;
            end else if (addr == ADDR_HOUR) begin
                n.rdata = s.hour;
            end else if (addr == ADDR_INTERVAL_MATCH_VALUE) begin
                n.rdata = s.interval_match_value;
            end else if (addr == ADDR_STATUS) begin
                n.rdata = {6'h00, s.status};
            end else if (addr == ADDR_MASK) begin
                n.rdata = {6'h00, s.mask};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s     <= '0;
            s.vec <= IRQ_VECTOR;
        end else begin
            s <= n;
        end
    end

    assign rdata      = s.rdata;
    assign irq        = s.irq;
    assign wake       = s.wake;
    assign irq_vector = s.vec;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence seq_wake_pulse;
        wake ##1 !wake;
    endsequence

    sequence seq_ctrl_read;
        rd && addr == ADDR_CTRL ##1 1'b1;
    endsequence

    a_match_sets_flag: assert property (match_evt |=> s.flag)
        else $error("match did not set flag");
    a_irq_holds: assert property (s.flag && s.status[ST_MATCH] && s.mask[ST_MATCH]
        |-> irq)
        else $error("interrupt not held");
    a_single_shot_stop: assert property (match_evt && s.single && !wr |=> !s.ien)
        else $error("single shot left counter enabled");
    a_auto_reload: assert property (match_evt && !s.single && !wr
        |=> s.ien && s.icnt == 8'h00)
        else $error("counter did not reload");
    a_disabled_zero: assert property (!s.ien |-> s.icnt == 8'h00)
        else $error("disabled counter not zero");
    a_time_range: assert property (!s.time_clock_enable || (s.frac <= FRAC_MAX
        && s.sec <= SEC_MAX && s.min <= MIN_MAX && s.hour <= HOUR_MAX))
        else $error("time register out of range");
    a_wake_pulse: assert property (match_evt && power_down && s.mask[ST_MATCH]
        |=> seq_wake_pulse)
        else $error("wake pulse wrong");
    a_ctrl_readback: assert property (seq_ctrl_read |-> rdata ==
        {2'b00, $past(s.sel), $past(s.single), $past(s.flag), $past(s.ien),
         $past(s.time_clock_enable)})
        else $error("control readback wrong");
    a_sec_carry: assert property (fwrap && s.sec != SEC_MAX && !wr
        |=> s.sec == 8'($past(s.sec) + 8'h01) && s.frac == 8'h00)
        else $error("seconds carry wrong");
    a_step_counts: assert property (s.ien && step && cnt_inc != s.interval_match_value && !wr
        |=> s.icnt == $past(cnt_inc))
        else $error("interval counter did not step");
    a_flag_sticky: assert property (s.flag && !(wr && addr == ADDR_CTRL)
        |=> s.flag)
        else $error("match flag dropped without software clear");
    a_status_sticky: assert property (s.status[ST_MATCH]
        && !(wr && addr == ADDR_STATUS) |=> s.status[ST_MATCH])
        else $error("match status dropped without software clear");
endmodule : itc_top

/* File: itc_pkg.sv */
// constants for the interval time counter
package itc_pkg;
    localparam int        DW             = 8;
    // register addresses
    localparam logic [7:0] ADDR_CTRL     = 8'ha1;
    localparam logic [7:0] ADDR_FRAC     = 8'ha2;
    localparam logic [7:0] ADDR_SEC      = 8'ha3;
    localparam logic [7:0] ADDR_MIN      = 8'ha4;
    localparam logic [7:0] ADDR_HOUR     = 8'ha5;
    localparam logic [7:0] ADDR_INTERVAL_MATCH_VALUE   = 8'ha6;
    localparam logic [7:0] ADDR_STATUS   = 8'ha7;
    localparam logic [7:0] ADDR_MASK     = 8'ha8;
    // control field positions
    localparam int        CTRL_TIME_CLOCK_ENABLE      = 0;
    localparam int        CTRL_IEN       = 1;
    localparam int        CTRL_FLAG      = 2;
    localparam int        CTRL_SINGLE    = 3;
    localparam int        CTRL_SEL_LO    = 4;
    localparam int        CTRL_SEL_HI    = 5;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    // status and mask bits
    localparam int        ST_MATCH       = 0;
    localparam int        ST_DAY         = 1;
    // timebase select encodings
    localparam logic [1:0] SEL_FRAC      = 2'h0;
    localparam logic [1:0] SEL_SEC       = 2'h1;
    localparam logic [1:0] SEL_MIN       = 2'h2;
    localparam logic [1:0] SEL_HOUR      = 2'h3;
    // counting limits
    localparam logic [7:0] FRAC_MAX      = 8'h7f;
    localparam logic [7:0] SEC_MAX       = 8'h3b;
    localparam logic [7:0] MIN_MAX       = 8'h3b;
    localparam logic [7:0] HOUR_MAX      = 8'h17;
    // crystal and tick timing
    localparam int        XTAL_HZ        = 32768;
    localparam int        TICKS_PER_SEC  = 128;
    localparam int        XTAL_PER_TICK  = XTAL_HZ / TICKS_PER_SEC;
    localparam logic [7:0] IRQ_VECTOR    = 8'h53;
endpackage : itc_pkg

/* File: itc_tb.sv */
// self-checking bench for the interval time counter
`timescale 1ns/1ps
module testbench
    import itc_pkg::*;
;
    logic       clk = 0, resetn = 0, xtal_pin = 0, power_down = 0, wr = 0, rd = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, irq_vector, v;
    logic       irq, wake, woke;
    int         error_cnt = 0, compares = 0, n, m;

    itc_top #(.XTAL_DIV(2)) u_itc_top (.clk(clk), .resetn(resetn), .xtal_pin(xtal_pin),
        .power_down(power_down), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .wake(wake), .irq_vector(irq_vector));

    always #5 clk = ~clk;
    // crystal stand-in, rising edge every 8 clocks
    always begin
        repeat (4) @(posedge clk);
        xtal_pin <= ~xtal_pin;
    end

    function automatic logic [7:0] ctrl_val(logic [1:0] s, logic sg, fl, ie, tc);
        return {2'h0, s, sg, fl, ie, tc};
    endfunction : ctrl_val

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic wait_irq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
            if (wake === 1'b1) woke = 1'b1;
        end
        if (n >= lim) begin
            error_cnt++;
            $display("mismatch at %0t: no interrupt", $time);
        end
    endtask : wait_irq

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        void'($urandom(44));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        // reset values, unmapped address reads zero
        for (int a = 8'ha1; a <= 8'ha9; a++) begin
            rd_reg(8'(a), v);
            chk(v, 8'h00);
        end
        chk(irq_vector, 8'h53);
        chk({7'h0, irq}, 8'h00);
        $display("test reset done");
        // time preload and readback while clock disabled, fraction masked
        wr_reg(ADDR_FRAC, 8'hff);
        wr_reg(ADDR_SEC, 8'h2a);
        rd_reg(ADDR_FRAC, v);
        chk(v, 8'h7f);
        rd_reg(ADDR_SEC, v);
        chk(v, 8'h2a);
        $display("test preload done");
        // every timebase code, preloaded one tick before its rollover
        wr_reg(ADDR_MASK, 8'h03);
        for (int s = 0; s < 4; s++) begin
            wr_reg(ADDR_CTRL, 8'h00);
            wr_reg(ADDR_FRAC, 8'h7f);
            wr_reg(ADDR_SEC, s >= 1 ? 8'h3b : 8'h00);
            wr_reg(ADDR_MIN, s >= 2 ? 8'h3b : 8'h00);
            m = $urandom % 23;
            wr_reg(ADDR_HOUR, s >= 3 ? 8'h17 : 8'(m));
            wr_reg(ADDR_INTERVAL_MATCH_VALUE, 8'h01);
            wr_reg(ADDR_STATUS, 8'h03);
            wr_reg(ADDR_CTRL, ctrl_val(2'(s), 1'b0, 1'b0, 1'b1, 1'b1));
            wait_irq(200);
            rd_reg(ADDR_CTRL, v);
            chk(v, ctrl_val(2'(s), 1'b0, 1'b1, 1'b1, 1'b1));
            rd_reg(s == 3 ? ADDR_HOUR : 8'(ADDR_SEC + s), v);
            chk(v, s == 3 ? 8'h00 : (s == 2 ? 8'(m + 1) : 8'h01));
            rd_reg(ADDR_STATUS, v);
            chk(v, s == 3 ? 8'h03 : 8'h01);
        end
        $display("test timebase done");
        // tick timing with random match value, wake from power-down
        m = 2 + $urandom % 3;
        wr_reg(ADDR_CTRL, 8'h00);
        wr_reg(ADDR_STATUS, 8'h03);
        wr_reg(ADDR_INTERVAL_MATCH_VALUE, 8'(m));
        power_down <= 1'b1;
        woke = 1'b0;
        wr_reg(ADDR_CTRL, ctrl_val(2'h0, 1'b0, 1'b0, 1'b1, 1'b1));
        wait_irq(400);
        chk({7'h0, n > (m - 1) * 16 && n <= m * 16 + 8}, 8'h01);
        chk({7'h0, woke}, 8'h01);
        @(posedge clk);
        power_down <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk({7'h0, irq}, 8'h01);
        wr_reg(ADDR_CTRL, 8'h00);
        wr_reg(ADDR_STATUS, 8'h01);
        #1 chk({7'h0, irq}, 8'h00);
        rd_reg(ADDR_SEC, v);
        chk(v, 8'h00);
        rd_reg(ADDR_CTRL, v);
        chk(v, 8'h00);
        $display("test interval done");
        // single shot drops the count enable at timeout
        wr_reg(ADDR_INTERVAL_MATCH_VALUE, 8'h02);
        wr_reg(ADDR_CTRL, ctrl_val(2'h0, 1'b1, 1'b0, 1'b1, 1'b1));
        wait_irq(200);
        rd_reg(ADDR_CTRL, v);
        chk(v, ctrl_val(2'h0, 1'b1, 1'b1, 1'b0, 1'b1));
        wr_reg(ADDR_MASK, 8'h00);
        #1 chk({7'h0, irq}, 8'h00);
        $display("test single shot done");
        report_and_stop();
    end
endmodule : testbench
